// ### rtl/cluster_consts.vh
// constants for the logic cluster cell array
`ifndef CLUSTER_CONSTS_VH
`define CLUSTER_CONSTS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define CL_CELLS        10
`define CL_ROW_CLKS     8
`define CL_LOCAL_LINES  8
`define CL_LUT_BITS     16
`define CL_CFG_BITS     17

// ----------------------------------------------------------------
// register map, byte offsets, and page codes for address bits 7:6
// ----------------------------------------------------------------
`define CL_CTL0_OFF     8'h00
`define CL_CTL1_OFF     8'h04
`define CL_STATE_OFF    8'h08
`define CL_LUT_PAGE     2'b01
`define CL_CFG_PAGE     2'b10

// ----------------------------------------------------------------
// control select fields, 4 bits each: bit3 local, bits2:0 index; CL_B_BOTHEDGE is a single bit
// ----------------------------------------------------------------
`define CL_F_CLK1       0
`define CL_F_ENA1       4
`define CL_F_CLK2       8
`define CL_F_ENA2       12
`define CL_F_ACLR1      16
`define CL_F_ACLR2      20
`define CL_F_SCLR       24
`define CL_F_ALOAD      28
`define CL_F_SLOAD      0
`define CL_F_ADDSUB     4
`define CL_B_BOTHEDGE   8

// ----------------------------------------------------------------
// cell configuration bits
// ----------------------------------------------------------------
`define CL_B_MODE_LO    0
`define CL_B_PAIR       2
`define CL_B_CLRSEL     3
`define CL_B_CLRUSE     4
`define CL_B_ALDUSE     5
`define CL_B_SCLRUSE    6
`define CL_B_SLDUSE     7
`define CL_B_IN3CARRY   8
`define CL_B_PACK       9
`define CL_B_LUTCHAIN   10
`define CL_B_REGCHAIN   11
`define CL_B_ARITH      12
`define CL_B_OUTA       13
`define CL_B_OUTB       14
`define CL_B_OUTL       15
`define CL_B_CHAINEND   16

// ----------------------------------------------------------------
// register kinds and reset values
// ----------------------------------------------------------------
`define CL_FF_D         2'h0
`define CL_FF_T         2'h1
`define CL_FF_JK        2'h2
`define CL_FF_SR        2'h3
`define CL_CTL0_RST     32'h0000_0000
`define CL_CTL1_RST     32'h0000_0000
`define CL_LUT_RST      16'h0000
`define CL_CFG_RST      17'h0_0000

`endif

// ### rtl/logic_cluster.v
// logic cluster of ten cells with wishbone configuration port
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "cluster_consts.vh"

module logic_cluster #(
    parameter CELLS = `CL_CELLS
) (
    input  wire                  clk_i,
    input  wire                  rst_i,
    input  wire [7:0]            wb_adr_i,
    input  wire [31:0]           wb_dat_i,
    input  wire [3:0]            wb_sel_i,
    input  wire                  wb_we_i,
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    input  wire [7:0]            row_clk_i,
    input  wire [7:0]            local_ctl_i,
    input  wire [4*CELLS-1:0]    cell_data_i,
    input  wire                  carry_in_zero_chain_i,
    input  wire                  carry_in_one_chain_i,
    input  wire                  cluster_carry_i,
    input  wire                  lut_chain_i,
    input  wire                  reg_chain_i,
    output reg  [CELLS-1:0]      out_a_o,
    output reg  [CELLS-1:0]      out_b_o,
    output reg  [CELLS-1:0]      out_local_o,
    output reg                   lut_chain_o,
    output reg                   reg_chain_o,
    output reg                   carry_out_o
);

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
function sel_line;
    input [3:0] f;
    input [7:0] row;
    input [7:0] loc;
    begin
        sel_line = f[3] ? loc[f[2:0]] : row[f[2:0]];
    end
endfunction

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer      b;
    begin
        merge = old;
        for (b = 0; b < 4; b = b + 1) begin
            if (sel[b])
                merge[8*b +: 8] = nw[8*b +: 8];
        end
    end
endfunction

// ----------------------------------------------------------------
// row clock synchroniser
// ----------------------------------------------------------------
reg  [7:0]              row_s1_r;
reg  [7:0]              row_s2_r;

always @(posedge clk_i) begin
    if (rst_i) begin
        row_s1_r <= 8'h00;
        row_s2_r <= 8'h00;
    end else begin
        row_s1_r <= row_clk_i;
        row_s2_r <= row_s1_r;
    end
end

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
reg  [31:0]             ctl0_r;
reg  [31:0]             ctl1_r;
reg  [`CL_LUT_BITS-1:0] lut_r [0:CELLS-1];
reg  [`CL_CFG_BITS-1:0] cfg_r [0:CELLS-1];
wire [CELLS-1:0]        q_w;
wire [CELLS-1:0]        lut_w;
wire [CELLS:0]          carry_w;

// ----------------------------------------------------------------
// cluster-wide control selection
// ----------------------------------------------------------------
wire clk1_lvl  = sel_line(ctl0_r[`CL_F_CLK1 +: 4], row_s2_r,
                          local_ctl_i);
wire ena1_lvl  = sel_line(ctl0_r[`CL_F_ENA1 +: 4], row_s2_r,
                          local_ctl_i);
wire clk2_lvl  = sel_line(ctl0_r[`CL_F_CLK2 +: 4], row_s2_r,
                          local_ctl_i);
wire ena2_lvl  = sel_line(ctl0_r[`CL_F_ENA2 +: 4], row_s2_r,
                          local_ctl_i);
wire aclr1_lvl = sel_line(ctl0_r[`CL_F_ACLR1 +: 4], row_s2_r,
                          local_ctl_i);
wire aclr2_lvl = sel_line(ctl0_r[`CL_F_ACLR2 +: 4], row_s2_r,
                          local_ctl_i);
wire sclr_lvl  = sel_line(ctl0_r[`CL_F_SCLR +: 4], row_s2_r,
                          local_ctl_i);
wire aload_lvl = sel_line(ctl0_r[`CL_F_ALOAD +: 4], row_s2_r,
                          local_ctl_i);
wire sload_lvl = sel_line(ctl1_r[`CL_F_SLOAD +: 4], row_s2_r,
                          local_ctl_i);
wire sub_lvl   = sel_line(ctl1_r[`CL_F_ADDSUB +: 4], row_s2_r,
                          local_ctl_i);
wire both_edge = ctl1_r[`CL_B_BOTHEDGE];

reg  [1:0]              clk_prev_r;

always @(posedge clk_i) begin
    if (rst_i)
        clk_prev_r <= 2'b00;
    else
        clk_prev_r <= {clk2_lvl, clk1_lvl};
end

// clock event gated by its own enable
wire ev1 = clk1_lvl & ~clk_prev_r[0] & ena1_lvl;
wire ev2_edge = both_edge ? (~clk2_lvl & clk_prev_r[1])
                          : (clk2_lvl & ~clk_prev_r[1]);
wire ev2 = ev2_edge & ena2_lvl;

// lsb carry in: forced high on subtract
assign carry_w[0] = sub_lvl ? 1'b1 :
                    (cluster_carry_i ? carry_in_one_chain_i
                                     : carry_in_zero_chain_i);

wire [CELLS-1:0] lut_prev = {lut_w[CELLS-2:0], lut_chain_i};
wire [CELLS-1:0] reg_prev = {q_w[CELLS-2:0], reg_chain_i};

// ----------------------------------------------------------------
// logic cells
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < CELLS; i = i + 1) begin : g_cell
        wire [3:0]  d   = cell_data_i[4*i +: 4];
        wire [16:0] c   = cfg_r[i];
        wire [15:0] tbl = lut_r[i];
        wire        cin = carry_w[i];
        reg         q_r;
        reg         q_nxt;
        wire        in0 = c[`CL_B_LUTCHAIN] ? lut_prev[i]
                                            : d[0];
        wire        in1 = d[1];
        wire        in2 = c[`CL_B_PACK] ? q_r :
                          (c[`CL_B_CHAINEND] ? sub_lvl : d[2]);
        wire        in3 = c[`CL_B_IN3CARRY] ? cin : d[3];
        wire        sub = sub_lvl & (c[`CL_B_ARITH] |
                          c[`CL_B_CHAINEND]);
        wire        bop = d[1] ^ sub;
        wire        sum = in0 ^ bop ^ cin;
        wire        cout = (in0 & bop) | (cin & (in0 ^ bop));
        wire        lut = tbl[{in3, in2, in1, in0}];
        wire        ev  = c[`CL_B_PAIR] ? ev2 : ev1;
        wire        aclr = c[`CL_B_CLRUSE] &
                           (c[`CL_B_CLRSEL] ? aclr2_lvl : aclr1_lvl);
        wire        ald = c[`CL_B_ALDUSE] & aload_lvl;
        wire        dsrc = c[`CL_B_REGCHAIN] ? reg_prev[i]
                                             : lut_w[i];

        assign lut_w[i] = c[`CL_B_ARITH] ? sum : lut;
        assign carry_w[i+1] = c[`CL_B_ARITH] ? cout : cin;
        assign q_w[i] = q_r;

        always @* begin
            case (c[`CL_B_MODE_LO +: 2])
                `CL_FF_D:  q_nxt = dsrc;
                `CL_FF_T:  q_nxt = q_r ^ dsrc;
                `CL_FF_JK: q_nxt = (dsrc & ~q_r) | (~d[1] & q_r);
                `CL_FF_SR: q_nxt = dsrc ? 1'b1 : (d[1] ? 1'b0 : q_r);
                default:   q_nxt = dsrc;
            endcase
        end

        always @(posedge clk_i) begin
            if (rst_i)
                q_r <= 1'b0;
            else if (aclr)
                q_r <= 1'b0;
            else if (ald)
                q_r <= d[3];
            else if (ev) begin
                if (c[`CL_B_SCLRUSE] & sclr_lvl)
                    q_r <= 1'b0;
                else if (c[`CL_B_SLDUSE] & sload_lvl)
                    q_r <= d[3];
                else
                    q_r <= q_nxt;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// cell outputs
// ----------------------------------------------------------------
integer k;

always @(posedge clk_i) begin
    if (rst_i) begin
        out_a_o     <= {CELLS{1'b0}};
        out_b_o     <= {CELLS{1'b0}};
        out_local_o <= {CELLS{1'b0}};
        lut_chain_o <= 1'b0;
        reg_chain_o <= 1'b0;
        carry_out_o <= 1'b0;
    end else begin
        for (k = 0; k < CELLS; k = k + 1) begin
            out_a_o[k]     <= cfg_r[k][`CL_B_OUTA] ? q_w[k]
                                                   : lut_w[k];
            out_b_o[k]     <= cfg_r[k][`CL_B_OUTB] ? q_w[k]
                                                   : lut_w[k];
            out_local_o[k] <= cfg_r[k][`CL_B_OUTL] ? q_w[k]
                                                   : lut_w[k];
        end
        lut_chain_o <= lut_w[CELLS-1];
        reg_chain_o <= q_w[CELLS-1];
        carry_out_o <= carry_w[CELLS];
    end
end

// ----------------------------------------------------------------
// wishbone slave
// ----------------------------------------------------------------
wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire        wr      = req & wb_we_i;
wire [3:0]  cidx    = wb_adr_i[5:2];
wire        cell_ok = (cidx < CELLS);
wire        lut_hit = (wb_adr_i[7:6] == `CL_LUT_PAGE) & cell_ok;
wire        cfg_hit = (wb_adr_i[7:6] == `CL_CFG_PAGE) & cell_ok;
reg  [31:0] rd_nxt;
reg  [31:0] old_w;
integer     n;

// byte-merged write word for the narrow per-cell registers
wire [31:0] wr_merged = merge(old_w, wb_dat_i, wb_sel_i);

always @* begin
    rd_nxt = 32'h0000_0000;
    old_w  = 32'h0000_0000;
    if (wb_adr_i == `CL_CTL0_OFF)
        rd_nxt = ctl0_r;
    else if (wb_adr_i == `CL_CTL1_OFF)
        rd_nxt = ctl1_r;
    else if (wb_adr_i == `CL_STATE_OFF)
        rd_nxt = {6'h00, lut_w, 6'h00, q_w};
    else if (lut_hit)
        rd_nxt = {16'h0000, lut_r[cidx]};
    else if (cfg_hit)
        rd_nxt = {15'h0000, cfg_r[cidx]};
    old_w = rd_nxt;
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        ctl0_r   <= `CL_CTL0_RST;
        ctl1_r   <= `CL_CTL1_RST;
        for (n = 0; n < CELLS; n = n + 1) begin
            lut_r[n] <= `CL_LUT_RST;
            cfg_r[n] <= `CL_CFG_RST;
        end
    end else begin
        wb_ack_o <= req;
        wb_dat_o <= req ? rd_nxt : 32'h0000_0000;
        if (wr && wb_adr_i == `CL_CTL0_OFF)
            ctl0_r <= merge(ctl0_r, wb_dat_i, wb_sel_i);
        if (wr && wb_adr_i == `CL_CTL1_OFF)
            ctl1_r <= merge(ctl1_r, wb_dat_i, wb_sel_i) & 32'h0000_01ff;
        if (wr && lut_hit)
            lut_r[cidx] <= wr_merged[`CL_LUT_BITS-1:0];
        if (wr && cfg_hit)
            cfg_r[cidx] <= wr_merged[`CL_CFG_BITS-1:0];
    end
end

endmodule // logic_cluster

// ### sim/cluster_checker.sv
// assertions on the logic cluster ports
`timescale 1ns/10ps
module cluster_checker #(
    parameter CELLS = 10
) (
    input wire               clk_i,
    input wire               rst_i,
    input wire               wb_cyc_i,
    input wire               wb_stb_i,
    input wire [31:0]        wb_dat_o,
    input wire               wb_ack_o,
    input wire [7:0]         row_clk_i,
    input wire [7:0]         local_ctl_i,
    input wire [4*CELLS-1:0] cell_data_i,
    input wire               carry_in_zero_chain_i,
    input wire               carry_in_one_chain_i,
    input wire               cluster_carry_i,
    input wire               lut_chain_i,
    input wire               reg_chain_i,
    input wire [CELLS-1:0]   out_a_o,
    input wire [CELLS-1:0]   out_b_o,
    input wire [CELLS-1:0]   out_local_o,
    input wire               lut_chain_o,
    input wire               reg_chain_o,
    input wire               carry_out_o
);
    // ----------------------------------------
    // quiet counter and properties
    // ----------------------------------------
    wire [4*CELLS+20:0] ins_w = {row_clk_i, local_ctl_i, cell_data_i,
        carry_in_zero_chain_i, carry_in_one_chain_i, cluster_carry_i,
        lut_chain_i, reg_chain_i};
    reg  [4*CELLS+20:0] prev_r;
    reg  [2:0]          quiet_r;
    always @(posedge clk_i) begin
        prev_r <= ins_w;
        if (rst_i || wb_cyc_i || ins_w != prev_r)
            quiet_r <= 3'd0;
        else if (quiet_r != 3'd7)
            quiet_r <= quiet_r + 3'd1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
    property p_rst_bus;
        $fell(rst_i) |-> !wb_ack_o;
    endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("ack at reset");
    property p_rst_out;
        $fell(rst_i) |-> (out_a_o | out_b_o | out_local_o) == 0
            && !carry_out_o && !lut_chain_o && !reg_chain_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs at reset");
    property p_quiet_cell;
        quiet_r == 3'd7 |=> $stable(out_a_o) && $stable(out_b_o)
            && $stable(out_local_o);
    endproperty
    a_quiet_cell: assert property (p_quiet_cell)
        else $error("cell output moved without cause");
    property p_quiet_chain;
        quiet_r == 3'd7 |=> $stable({lut_chain_o, reg_chain_o, carry_out_o});
    endproperty
    a_quiet_chain: assert property (p_quiet_chain)
        else $error("chain output moved without cause");
endmodule // cluster_checker

bind logic_cluster cluster_checker #(.CELLS(CELLS)) chk_u (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .row_clk_i, .local_ctl_i,
    .cell_data_i, .carry_in_zero_chain_i, .carry_in_one_chain_i,
    .cluster_carry_i, .lut_chain_i, .reg_chain_i, .out_a_o, .out_b_o,
    .out_local_o, .lut_chain_o, .reg_chain_o, .carry_out_o);

// ### sim/neighbour_model.sv
// far-side model: previous cluster chains and a row clock source
`timescale 1ns/10ps
module neighbour_model (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       fire_i,
    input  wire [2:0] line_i,
    output reg  [7:0] row_clk_o,
    output wire [4:0] chain_o
);
    // ----------------------------------------
    // row clock pulse, still between pulses
    // ----------------------------------------
    reg [2:0] hold_r;
    assign chain_o = 5'h00;
    always @(posedge clk_i) begin
        if (rst_i) begin
            row_clk_o <= 8'h00;
            hold_r    <= 3'd0;
        end else if (fire_i) begin
            row_clk_o <= 8'h01 << line_i;
            hold_r    <= 3'd4;
        end else if (hold_r != 3'd0) begin
            hold_r <= hold_r - 3'd1;
            if (hold_r == 3'd1)
                row_clk_o <= 8'h00;
        end
    end
endmodule // neighbour_model

// ### sim/test_logic_cluster.sv
// self-checking bench for the logic cluster
`timescale 1ns/10ps
module test_logic_cluster;
    // ----------------------------------------
    // signals, models and tasks
    // ----------------------------------------
    reg         clk_i       = 1'b0;
    reg         rst_i       = 1'b1;
    reg  [7:0]  wb_adr_i    = 8'h00;
    reg  [31:0] wb_dat_i    = 32'h0;
    reg  [3:0]  wb_sel_i    = 4'h0;
    reg         wb_we_i     = 1'b0;
    reg         wb_cyc_i    = 1'b0;
    reg         wb_stb_i    = 1'b0;
    reg  [7:0]  local_ctl_i = 8'h00;
    reg  [39:0] cell_data_i = 40'h0;
    reg         fire        = 1'b0;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire [7:0]  row_clk;
    wire [4:0]  chain;
    wire [9:0]  out_a_o;
    wire [9:0]  out_b_o;
    wire [9:0]  out_local_o;
    wire        carry_out_o;
    wire        lut_chain_o;
    wire        reg_chain_o;
    reg  [31:0] seed        = 32'hb9b46d33;
    reg  [31:0] rd;
    reg  [31:0] exp_v;
    reg  [15:0] mask [0:9];
    reg  [6:0]  step [0:4];
    integer     errors      = 0;
    integer     compares    = 0;
    integer     i, k, q;
    always #50 clk_i = ~clk_i;
    neighbour_model nb_u (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .line_i(3'h2), .row_clk_o(row_clk), .chain_o(chain));
    logic_cluster dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .row_clk_i(row_clk), .local_ctl_i(local_ctl_i),
        .cell_data_i(cell_data_i), .carry_in_zero_chain_i(chain[0]),
        .carry_in_one_chain_i(chain[1]), .cluster_carry_i(chain[2]),
        .lut_chain_i(chain[3]), .reg_chain_i(chain[4]), .out_a_o(out_a_o),
        .out_b_o(out_b_o), .out_local_o(out_local_o),
        .lut_chain_o(lut_chain_o), .reg_chain_o(reg_chain_o),
        .carry_out_o(carry_out_o));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task rnd;
        repeat (32) seed = lfsr(seed);
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        integer n;
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= s;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 16) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n == 16) begin
                errors = errors + 1;
                report_and_stop;
            end
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    initial begin
        tick(10);
        rst_i <= 1'b0;
        bus(0, 8'h00, 32'h0, 4'hf);
        chk("ctl0", 32'h0, rd);
        bus(0, 8'h04, 32'h0, 4'hf);
        chk("ctl1", 32'h0, rd);
        rnd;
        exp_v = seed | 32'h00ff0000;
        bus(1, 8'h00, seed, 4'hf);
        bus(1, 8'h00, 32'hffffffff, 4'b0100);
        bus(0, 8'h00, 32'h0, 4'hf);
        chk("ctl0", exp_v, rd);
        bus(1, 8'h04, 32'hffffffff, 4'hf);
        bus(0, 8'h04, 32'h0, 4'hf);
        chk("ctl1", 32'h000001ff, rd);
        bus(0, 8'h0c, 32'h0, 4'hf);
        chk("unmapped", 32'h0, rd);
        $display("register test done");
        for (k = 0; k < 10; k = k + 1) begin
            rnd;
            mask[k] = seed[15:0];
            bus(1, 8'h40 | {k[5:0], 2'b00}, {16'h0, seed[15:0]}, 4'hf);
        end
        for (i = 0; i < 8; i = i + 1) begin
            rnd;
            @(posedge clk_i);
            cell_data_i <= {seed[7:0], lfsr(seed)};
            tick(3);
            exp_v = 32'h0;
            for (k = 0; k < 10; k = k + 1)
                exp_v[k] = mask[k][cell_data_i[4 * k +: 4]];
            chk("out_a", exp_v, {22'h0, out_a_o});
            chk("out_b", exp_v, {22'h0, out_b_o});
            chk("out_local", exp_v, {22'h0, out_local_o});
            chk("lut_chain", exp_v[9], {31'h0, lut_chain_o});
            chk("reg_chain", 32'h0, {31'h0, reg_chain_o});
            chk("carry_pass", 32'h0, {31'h0, carry_out_o});
            bus(0, 8'h08, 32'h0, 4'hf);
            chk("state", exp_v << 16, rd);
        end
        $display("table test done");
        bus(1, 8'h00, 32'ha0090082, 4'hf);
        bus(1, 8'h80, 32'h00002030, 4'hf);
        bus(1, 8'h40, 32'h0000aaaa, 4'hf);
        step = '{7'h16, 7'h02, 7'h12, 7'h48, 7'h68};
        q = 0;
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clk_i);
            local_ctl_i <= {5'h00, step[i][6:4]};
            cell_data_i <= {36'h0, step[i][3], 2'b00, step[i][2]};
            fire <= step[i][1];
            @(posedge clk_i);
            fire <= 1'b0;
            tick(10);
            if (step[i][5])
                q = 0;
            else if (step[i][6])
                q = step[i][3];
            else if (step[i][1] && step[i][4])
                q = step[i][2];
            chk("cell reg", q, {31'h0, out_a_o[0]});
        end
        $display("register cell test done");
        bus(1, 8'h04, 32'h000000b0, 4'hf);
        for (k = 0; k < 10; k = k + 1)
            bus(1, 8'h80 | {k[5:0], 2'b00}, 32'h00001000, 4'hf);
        for (i = 0; i < 8; i = i + 1) begin
            rnd;
            @(posedge clk_i);
            local_ctl_i <= {4'h0, seed[20], 3'h0};
            for (k = 0; k < 10; k = k + 1)
                cell_data_i[4 * k +: 4] <= {2'b00, seed[10 + k], seed[k]};
            tick(4);
            exp_v = {22'h0, seed[9:0]} + seed[20] +
                {22'h0, seed[20] ? ~seed[19:10] : seed[19:10]};
            chk("sum", exp_v & 32'h3ff, {22'h0, out_a_o});
            chk("carry", exp_v >> 10, {31'h0, carry_out_o});
        end
        $display("arithmetic test done");
        report_and_stop;
    end
endmodule // test_logic_cluster
